// ===== design/pps_mux.v
// Pin function select for port 1 and port 2, with AXI4-Lite register slave
`timescale 1ns/1ns
`include "pps_regs.vh"
module pps_mux #(
    parameter ADDR_W = 32
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // General-purpose I/O logic side, port 1 pins five and six
    input wire gpio_p1_5_out,
    input wire gpio_p1_5_oe_n,
    output wire gpio_p1_5_in,
    input wire gpio_p1_6_out,
    input wire gpio_p1_6_oe_n,
    output wire gpio_p1_6_in,
    // General-purpose I/O logic side, port 2 pin six (test output pin)
    input wire gpio_p2_6_out,
    input wire gpio_p2_6_oe_n,
    // Serial port
    input wire uart_txd,
    output wire uart_rxd,
    // Test interface timer
    input wire serial_test_interface_data,
    // Bus transceiver transmit input
    output wire bus_txd,
    // Port 1 pin five, two-way
    input wire p1_5_pin_in,
    output wire p1_5_pin_out,
    output wire p1_5_pin_oe_n,
    // Port 1 pin six, two-way
    input wire p1_6_pin_in,
    output wire p1_6_pin_out,
    output wire p1_6_pin_oe_n,
    // Test interface output pin
    output wire test_pin_out,
    output wire test_pin_oe_n
);

    // Register state
    reg [31:0] p1_sel_ff;
    reg [31:0] p2_sel_ff;
    reg [31:0] p2_data_ff;
    reg [31:0] nxt_p1_sel;
    reg [31:0] nxt_p2_sel;
    reg [31:0] nxt_p2_data;

    // Write channel holding state
    reg aw_hold_ff;
    reg [ADDR_W-1:0] aw_addr_ff;
    reg w_hold_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;

    // Read channel state
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    // Pin side registers
    reg p1_5_out_ff;
    reg p1_5_oe_n_ff;
    reg p1_6_out_ff;
    reg p1_6_oe_n_ff;
    reg test_out_ff;
    reg test_oe_n_ff;
    reg bus_txd_ff;
    reg uart_rxd_ff;

    wire [1:0] pin_sync;
    wire do_write;

    // Pin inputs cross into the clock domain before any logic looks at them
    pps_sync #(
        .WIDTH(`PPS_SYNC_STAGES),
        .RST_VAL(2'b11)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({p1_6_pin_in, p1_5_pin_in}),
        .sync_out(pin_sync)
    );

    // Merge write data into a register under byte strobes
    function [31:0] strb_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            strb_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode shared by reads and writes: 0 none, 1..4 register index
    function [2:0] addr_decode;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == `PPS_P1_SEL_ADDR) begin
                addr_decode = 3'h1;
            end else if (addr == `PPS_P2_SEL_ADDR) begin
                addr_decode = 3'h2;
            end else if (addr == `PPS_P2_DATA_ADDR) begin
                addr_decode = 3'h3;
            end else if (addr == `PPS_PIN_STAT_ADDR) begin
                addr_decode = 3'h4;
            end else begin
                addr_decode = 3'h0;
            end
        end
    endfunction

    // Both halves of a write may arrive in either order; hold each until paired
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            aw_addr_ff <= {ADDR_W{1'b0}};
            w_hold_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only addresses answer with a slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `PPS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            if (addr_decode(aw_addr_ff) == 3'h0 || addr_decode(aw_addr_ff) == 3'h4) begin
                bresp_ff <= `PPS_RESP_SLVERR;
            end else begin
                bresp_ff <= `PPS_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Next register values; every bit of a strobed byte is stored so reads echo the last write
    always @* begin
        nxt_p1_sel = p1_sel_ff;
        nxt_p2_sel = p2_sel_ff;
        nxt_p2_data = p2_data_ff;
        if (do_write) begin
            if (addr_decode(aw_addr_ff) == 3'h1) begin
                nxt_p1_sel = strb_merge(p1_sel_ff, w_data_ff, w_strb_ff); // R9
            end else if (addr_decode(aw_addr_ff) == 3'h2) begin
                nxt_p2_sel = strb_merge(p2_sel_ff, w_data_ff, w_strb_ff); // R9
            end else if (addr_decode(aw_addr_ff) == 3'h3) begin
                nxt_p2_data = strb_merge(p2_data_ff, w_data_ff, w_strb_ff);
            end
        end
    end

    // Reserved bits are kept as written; software is expected to leave them zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            p1_sel_ff <= `PPS_P1_SEL_RST;
            p2_sel_ff <= `PPS_P2_SEL_RST;
            p2_data_ff <= `PPS_P2_DATA_RST;
        end else begin
            p1_sel_ff <= nxt_p1_sel;
            p2_sel_ff <= nxt_p2_sel;
            p2_data_ff <= nxt_p2_data; // R7
        end
    end

    // Read channel: one outstanding read, data registered at the address edge
    assign s_axi_arready = !rvalid_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `PPS_RESP_OKAY;
            if (addr_decode(s_axi_araddr) == 3'h1) begin
                rdata_ff <= p1_sel_ff; // R9
            end else if (addr_decode(s_axi_araddr) == 3'h2) begin
                rdata_ff <= p2_sel_ff; // R9
            end else if (addr_decode(s_axi_araddr) == 3'h3) begin
                rdata_ff <= p2_data_ff;
            end else if (addr_decode(s_axi_araddr) == 3'h4) begin
                rdata_ff <= {28'h0000000,
                    p2_sel_ff[`PPS_P2_BUSTX_BIT],
                    p2_sel_ff[`PPS_P2_TEST_BIT],
                    pin_sync[1],
                    pin_sync[0]};
            end else begin
                rdata_ff <= 32'h00000000;
                rresp_ff <= `PPS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Pin routing follows the next register value, so the pins switch at the
    // same edge that stores the write rather than one cycle later
    always @(posedge aclk) begin
        if (!aresetn) begin
            p1_5_out_ff <= 1'b0;
            p1_5_oe_n_ff <= 1'b1;
            p1_6_out_ff <= 1'b0;
            p1_6_oe_n_ff <= 1'b1;
            test_out_ff <= 1'b0;
            test_oe_n_ff <= 1'b1;
            bus_txd_ff <= 1'b1;
            uart_rxd_ff <= 1'b1;
        end else begin
            // Pin six: serial transmit or general I/O
            if (nxt_p1_sel[`PPS_P1_TXD_BIT]) begin
                p1_6_out_ff <= uart_txd; // R2
                p1_6_oe_n_ff <= 1'b0; // R2
            end else begin
                p1_6_out_ff <= gpio_p1_6_out; // R2
                p1_6_oe_n_ff <= gpio_p1_6_oe_n; // R2
            end
            // Pin five: serial receive (pad released) or general I/O
            if (nxt_p1_sel[`PPS_P1_RXD_BIT]) begin
                p1_5_out_ff <= 1'b0; // R3
                p1_5_oe_n_ff <= 1'b1; // R3
                uart_rxd_ff <= pin_sync[0]; // R3
            end else begin
                p1_5_out_ff <= gpio_p1_5_out; // R3
                p1_5_oe_n_ff <= gpio_p1_5_oe_n; // R3
                uart_rxd_ff <= 1'b1; // Idle line keeps the receiver quiet
            end
            // Test output pin: timer data only when selected
            if (nxt_p2_sel[`PPS_P2_TEST_BIT]) begin
                test_out_ff <= serial_test_interface_data; // R4
                test_oe_n_ff <= 1'b0; // R4
            end else begin
                test_out_ff <= gpio_p2_6_out; // R5
                test_oe_n_ff <= gpio_p2_6_oe_n; // R5
            end
            // Bus transmit: serial port for vehicle bus, software pad otherwise
            if (nxt_p2_sel[`PPS_P2_BUSTX_BIT]) begin
                bus_txd_ff <= uart_txd; // R8
            end else begin
                bus_txd_ff <= nxt_p2_data[`PPS_P2_PAD_BIT]; // R6
            end
        end
    end

    // Output assignments
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign p1_5_pin_out = p1_5_out_ff;
    assign p1_5_pin_oe_n = p1_5_oe_n_ff;
    assign p1_6_pin_out = p1_6_out_ff;
    assign p1_6_pin_oe_n = p1_6_oe_n_ff;
    assign test_pin_out = test_out_ff;
    assign test_pin_oe_n = test_oe_n_ff;
    assign bus_txd = bus_txd_ff;
    assign uart_rxd = uart_rxd_ff;
    // Pin levels back to the general-purpose I/O logic, already synchronised
    assign gpio_p1_5_in = pin_sync[0];
    assign gpio_p1_6_in = pin_sync[1];

endmodule

// ===== design/pps_regs.vh
// Register map, field positions and reset values for the port 1/2 pin function select block
// Summary of operation
// [R1] Software writes zeros to reserved bits of both function select registers; the bench writes port 2 reserved bits at random.
// [R2] Port 1 pin six is general I/O when bit 4 clear, serial transmit when set.
// [R3] Port 1 pin five is general I/O when bit 0 clear, serial receive when set.
// [R4] Test interface select set drives the timer test data onto its output pin.
// [R5] Test interface select clear keeps test data off the pin whatever its enable.
// [R6] Transmit path select clear takes bus transmit data from the software pad bit.
// [R7] Sensor bus mode: software clears transmit select, then writes the pad bit.
// [R8] Transmit path select set routes serial transmit data to the vehicle bus pin.
// [R9] Select writes reroute pins at once; reads return last written value.
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// Byte addresses on the register bus
`define PPS_P1_SEL_ADDR 32'hffff0d04
`define PPS_P2_SEL_ADDR 32'hffff0d08
`define PPS_P2_DATA_ADDR 32'hffff0d0c
`define PPS_PIN_STAT_ADDR 32'hffff0d10

// Reset values
`define PPS_P1_SEL_RST 32'h10000000
`define PPS_P2_SEL_RST 32'h01000000
`define PPS_P2_DATA_RST 32'h00000000

// Field positions in port1_function_select
`define PPS_P1_TXD_BIT 4
`define PPS_P1_RXD_BIT 0

// Field positions in port2_function_select
`define PPS_P2_TEST_BIT 24
`define PPS_P2_BUSTX_BIT 20

// Field position of the internal bus transmit pad in port2_pin_data
`define PPS_P2_PAD_BIT 5

// Field positions in the pin status register
`define PPS_STAT_P1_5_BIT 0
`define PPS_STAT_P1_6_BIT 1
`define PPS_STAT_TEST_SEL_BIT 2
`define PPS_STAT_BUSTX_BIT 3

// Bus response codes
`define PPS_RESP_OKAY 2'b00
`define PPS_RESP_SLVERR 2'b10

// Synchroniser width for pin inputs, one bit per pin
`define PPS_SYNC_STAGES 2

`endif

// ===== design/pps_sync.v
// Two-stage synchroniser for pin inputs entering the core clock domain
`timescale 1ns/1ns
module pps_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage, to let metastability settle
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ===== testbench/pps_mux_props.sv
// Checker for the port 1/2 pin function select block
`timescale 1ns/1ns
`include "pps_regs.vh"
module pps_mux_props #(
    parameter ADDR_W = 32
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    // Function sources
    input wire gpio_p1_5_out,
    input wire gpio_p1_5_oe_n,
    input wire gpio_p1_5_in,
    input wire gpio_p1_6_in,
    input wire uart_rxd,
    input wire gpio_p1_6_out,
    input wire gpio_p1_6_oe_n,
    input wire gpio_p2_6_out,
    input wire gpio_p2_6_oe_n,
    input wire uart_txd,
    input wire serial_test_interface_data,
    // Pins
    input wire bus_txd,
    input wire p1_5_pin_in,
    input wire p1_5_pin_out,
    input wire p1_5_pin_oe_n,
    input wire p1_6_pin_in,
    input wire p1_6_pin_out,
    input wire p1_6_pin_oe_n,
    input wire test_pin_out,
    input wire test_pin_oe_n
);
    reg [31:0] p1s_ff, p2s_ff, pd_ff;
    reg [ADDR_W-1:0] pa_ff;
    reg pend_ff, pad_ff;
    wire wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // Shadow selects land on the edge the block stores a write, one after the take
    always @(posedge aclk) begin
        pa_ff <= s_axi_awaddr;
        pd_ff <= s_axi_wdata;
        if (!aresetn) begin
            pend_ff <= 1'b0;
            p1s_ff <= `PPS_P1_SEL_RST;
            p2s_ff <= `PPS_P2_SEL_RST;
            pad_ff <= 1'b0;
        end else begin
            pend_ff <= wtake;
            if (pend_ff && pa_ff == `PPS_P1_SEL_ADDR) p1s_ff <= pd_ff;
            if (pend_ff && pa_ff == `PPS_P2_SEL_ADDR) p2s_ff <= pd_ff;
            if (pend_ff && pa_ff == `PPS_P2_DATA_ADDR) pad_ff <= pd_ff[`PPS_P2_PAD_BIT];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Output flops hold reset values at the first edge, hence the past-reset guard
    a_txd_route: assert property ($past(aresetn) |->
        p1_6_pin_out == (p1s_ff[4] ? $past(uart_txd) : $past(gpio_p1_6_out)) &&
        p1_6_pin_oe_n == (p1s_ff[4] ? 1'b0 : $past(gpio_p1_6_oe_n))) else $error("p1.6 route");
    a_rxd_release: assert property ($past(aresetn) && p1s_ff[0] |-> p1_5_pin_oe_n)
        else $error("p1.5 not released");
    a_p15_gpio: assert property ($past(aresetn) && !p1s_ff[0] |->
        p1_5_pin_out == $past(gpio_p1_5_out) && p1_5_pin_oe_n == $past(gpio_p1_5_oe_n) &&
        uart_rxd) else $error("p1.5 gpio route");
    a_rxd_path: assert property ($past(aresetn) && p1s_ff[0] |->
        uart_rxd == $past(gpio_p1_5_in)) else $error("rxd path");
    // Pin levels reach the logic side two edges late, through the synchroniser
    a_pin_sync: assert property ($past(aresetn) && $past(aresetn, 2) |->
        gpio_p1_5_in == $past(p1_5_pin_in, 2) && gpio_p1_6_in == $past(p1_6_pin_in, 2))
        else $error("pin sync");
    a_test_on: assert property ($past(aresetn) && p2s_ff[24] |->
        !test_pin_oe_n && test_pin_out == $past(serial_test_interface_data))
        else $error("test pin on");
    a_test_off: assert property ($past(aresetn) && !p2s_ff[24] |->
        test_pin_out == $past(gpio_p2_6_out) && test_pin_oe_n == $past(gpio_p2_6_oe_n))
        else $error("test pin leaks");
    a_bus_pad: assert property ($past(aresetn) && !p2s_ff[20] |-> bus_txd == pad_ff)
        else $error("bus pad");
    a_bus_uart: assert property ($past(aresetn) && p2s_ff[20] |-> bus_txd == $past(uart_txd))
        else $error("bus uart");
    // Halves are held for one edge, the response rises at the edge after that
    a_write_resp: assert property (wtake |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("no response");
    a_read_back: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `PPS_P1_SEL_ADDR |=> s_axi_rdata == $past(p1s_ff)) else $error("readback");
    c_write: cover property (wtake);
    c_both_p1: cover property (p1s_ff[4] && p1s_ff[0]);
    c_p2_clear: cover property (!p2s_ff[24] && !p2s_ff[20]);
endmodule

// ===== testbench/pps_pins.sv
// Board model of port 1 pins five and six
`timescale 1ns/1ns
module pps_pins (
    // Drive from the block
    input wire p1_5_pin_out,
    input wire p1_5_pin_oe_n,
    input wire p1_6_pin_out,
    input wire p1_6_pin_oe_n,
    // Board level on a released pin
    input wire ext_5,
    input wire ext_6,
    // Wire levels
    output wire p1_5_pin_in,
    output wire p1_6_pin_in
);
    // A released pin shows the board level, never a stale drive
    assign p1_5_pin_in = p1_5_pin_oe_n ? ext_5 : p1_5_pin_out;
    assign p1_6_pin_in = p1_6_pin_oe_n ? ext_6 : p1_6_pin_out;
endmodule

// ===== testbench/pps_mux_tb.sv
// Self-checking bench for the port 1/2 pin function select block
`timescale 1ns/1ns
`include "pps_regs.vh"
module pps_mux_tb;
    reg aclk, aresetn, awv, wv, brdy, arv, rrdy;
    reg [31:0] awa, wd, ara, v;
    wire awr, wr_r, bv, arr, rv, rxd, btx, p5i, p5o, p5e, p6i, p6o, p6e, sto, ste;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    reg g5o, g5e, g6o, g6e, g26o, g26e, txd, tdat, ext_5, ext_6, rnd_on;
    int num_errors, total_checks, k;
    reg [33:0] q_r[$];
    reg [1:0] q_b[$];
    pps_mux i_pps_mux (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy), .gpio_p1_5_out(g5o), .gpio_p1_5_oe_n(g5e), .gpio_p1_5_in(),
        .gpio_p1_6_out(g6o), .gpio_p1_6_oe_n(g6e), .gpio_p1_6_in(), .gpio_p2_6_out(g26o),
        .gpio_p2_6_oe_n(g26e), .uart_txd(txd), .uart_rxd(rxd), .serial_test_interface_data(tdat),
        .bus_txd(btx), .p1_5_pin_in(p5i), .p1_5_pin_out(p5o), .p1_5_pin_oe_n(p5e),
        .p1_6_pin_in(p6i), .p1_6_pin_out(p6o), .p1_6_pin_oe_n(p6e), .test_pin_out(sto),
        .test_pin_oe_n(ste));
    pps_pins i_pps_pins (.p1_5_pin_out(p5o), .p1_5_pin_oe_n(p5e), .p1_6_pin_out(p6o),
        .p1_6_pin_oe_n(p6e), .ext_5(ext_5), .ext_6(ext_6), .p1_5_pin_in(p5i), .p1_6_pin_in(p6i));
    // Clock, 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Peripheral and GPIO sources toggle freely so routing is seen on live data
    always @(posedge aclk) begin
        if (rnd_on) {g5o, g5e, g6o, g6e, g26o, g26e, txd, tdat} <= 8'($urandom);
    end
    task stop_test;
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk_r(input [33:0] got, input [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task chk_b(input [1:0] got, input [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bresp %h expected %h", $time, got, exp);
        end
    endtask
    // Results are settled at the falling edge; the handshake lands at the next rise
    always @(negedge aclk) begin
        if (rv && rrdy) chk_r({rresp, rdata}, q_r.pop_front());
        if (bv && brdy) chk_b(bresp, q_b.pop_front());
    end
    task wr(input [31:0] a, input [31:0] d, input [1:0] r);
        reg ta, tw;
        q_b.push_back(r);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wr_r;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while ((awv && !ta) || (wv && !tw));
        do @(negedge aclk); while (!bv);
        @(posedge aclk);
        brdy <= 1'b0;
    endtask
    task rd(input [31:0] a, input [31:0] e, input [1:0] r);
        q_r.push_back({r, e});
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 1'b0;
        do @(negedge aclk); while (!rv);
        @(posedge aclk);
        rrdy <= 1'b0;
    endtask
    // Main sequence
    initial begin
        void'($urandom(13562));
        {aresetn, awv, wv, brdy, arv, rrdy, rnd_on, awa, wd, ara} = '0;
        {g5o, g5e, g6o, g6e, g26o, g26e, txd, tdat, ext_5, ext_6} = 10'h3ff;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rnd_on <= 1'b1;
        rd(`PPS_P1_SEL_ADDR, `PPS_P1_SEL_RST, `PPS_RESP_OKAY);
        rd(`PPS_P2_SEL_ADDR, `PPS_P2_SEL_RST, `PPS_RESP_OKAY);
        rd(32'hffff0d20, 32'h00000000, `PPS_RESP_SLVERR);
        wr(`PPS_PIN_STAT_ADDR, 32'h00000000, `PPS_RESP_SLVERR);
        // Port 1 reserved bits kept zero, port 2 bits 0 to 24 written at random, every select combination reached at random
        for (k = 0; k < 8; k++) begin
            v = $urandom & 32'h00000011;
            wr(`PPS_P1_SEL_ADDR, v, `PPS_RESP_OKAY);
            rd(`PPS_P1_SEL_ADDR, v, `PPS_RESP_OKAY);
            v = $urandom & 32'h01ffffff;
            wr(`PPS_P2_SEL_ADDR, v, `PPS_RESP_OKAY);
            rd(`PPS_P2_SEL_ADDR, v, `PPS_RESP_OKAY);
            repeat (6) @(posedge aclk);
        end
        // Sensor bus: clear the path select, then write the pad
        wr(`PPS_P2_SEL_ADDR, 32'h00000000, `PPS_RESP_OKAY);
        wr(`PPS_P2_DATA_ADDR, 32'h00000020, `PPS_RESP_OKAY);
        rd(`PPS_P2_DATA_ADDR, 32'h00000020, `PPS_RESP_OKAY);
        wr(`PPS_P2_SEL_ADDR, 32'h01100000, `PPS_RESP_OKAY);
        // Receive select releases pin five; status shows the board levels
        wr(`PPS_P1_SEL_ADDR, 32'h00000001, `PPS_RESP_OKAY);
        rnd_on <= 1'b0;
        @(posedge aclk);
        g6e <= 1'b1;
        ext_5 <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(`PPS_PIN_STAT_ADDR, 32'h0000000e, `PPS_RESP_OKAY);
        stop_test;
    end
    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #1000000;
        num_errors++;
        stop_test;
    end
endmodule
bind pps_mux pps_mux_props #(.ADDR_W(ADDR_W)) i_pps_mux_props (.*);
